// ==== common/rmc_pkg.sv ====
// package of offsets, field positions and reset values for the main config bank
package rmc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte addresses are four times these)
    // ------------------------------------------------------------------
    localparam logic [4:0] IDX_MODE_BAND     = 5'h00;
    localparam logic [4:0] IDX_DATA_MOD      = 5'h01;
    localparam logic [4:0] IDX_FSK_DEV       = 5'h02;
    localparam logic [4:0] IDX_BR_C          = 5'h03;
    localparam logic [4:0] IDX_BR_D          = 5'h04;
    localparam logic [4:0] IDX_AMP_RAMP_TIME       = 5'h05;
    localparam logic [4:0] IDX_REF_DIV_A     = 5'h06;
    localparam logic [4:0] IDX_P_CNT_A       = 5'h07;
    localparam logic [4:0] IDX_S_CNT_A       = 5'h08;
    localparam logic [4:0] IDX_REF_DIV_B     = 5'h09;
    localparam logic [4:0] IDX_P_CNT_B       = 5'h0a;
    localparam logic [4:0] IDX_S_CNT_B       = 5'h0b;
    // parameter group boundaries
    localparam logic [4:0] IDX_MAIN_LAST     = 5'h0b;
    localparam logic [4:0] IDX_IRQ_FIRST     = 5'h0c;
    localparam logic [4:0] IDX_IRQ_LAST      = 5'h0f;
    localparam logic [4:0] IDX_RX_FIRST      = 5'h10;
    localparam logic [4:0] IDX_RX_LAST       = 5'h15;
    localparam logic [4:0] IDX_SYNC_FIRST    = 5'h16;
    localparam logic [4:0] IDX_SYNC_LAST     = 5'h19;
    localparam logic [4:0] IDX_TX_GROUP      = 5'h1a;
    localparam logic [4:0] IDX_OSC_GROUP     = 5'h1b;
    localparam logic [4:0] IDX_PKT_FIRST     = 5'h1c;
    localparam logic [4:0] IDX_PKT_LAST      = 5'h1e;
    localparam int         NUM_MAIN_REGS     = 12;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int POS_MODE      = 5;   // bits 7-5 of index 0
    localparam int POS_BAND      = 2;   // bits 4-2 of index 0
    localparam int POS_SUBBAND   = 0;   // bits 1-0 of index 0
    localparam int POS_DATAMODE  = 6;   // bits 7-6 of index 1
    localparam int POS_MODSEL    = 4;   // bits 5-4 of index 1
    localparam int POS_SLICER    = 2;   // bits 3-2 of index 1
    localparam int POS_IFGAIN    = 0;   // bits 1-0 of index 1
    localparam int POS_RAMP      = 6;   // bits 7-6 of index 5
    localparam int POS_LOWPWR    = 5;   // bit 5 of index 5
    localparam int POS_TRIM      = 1;   // bits 2-1 of index 5
    localparam int POS_SETSEL    = 0;   // bit 0 of index 5

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_MODE_BAND = 8'h30; // stby, 430-470, q1
    localparam logic [7:0] RST_DATA_MOD  = 8'h24; // cont, fsk, peak, 0dB
    localparam logic [7:0] RST_FSK_DEV   = 8'h03;
    localparam logic [7:0] RST_BR_C      = 8'h07;
    localparam logic [7:0] RST_BR_D      = 8'h0f;
    localparam logic [7:0] RST_AMP_RAMP_TIME   = 8'hc6; // 23us, normal, trim 11
    localparam logic [7:0] RST_REF_DIV_A = 8'h6b;
    localparam logic [7:0] RST_P_CNT_A   = 8'h2a;
    localparam logic [7:0] RST_S_CNT_A   = 8'h1e;
    localparam logic [7:0] RST_REF_DIV_B = 8'h77;
    localparam logic [7:0] RST_P_CNT_B   = 8'h2f;
    localparam logic [7:0] RST_S_CNT_B   = 8'h19;
    // writable bit masks (index 5 bits 4-3 are unused, read zero)
    localparam logic [7:0] MASK_AMP_RAMP_TIME  = 8'he7;

    // ------------------------------------------------------------------
    // enumerations of decoded modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TRX_SLEEP, TRX_STANDBY, TRX_SYNTH_ONLY, TRX_RECEIVE,
        TRX_TRANSMIT, TRX_UNDEFINED
    } rmc_trx_mode_type;

    typedef enum logic [1:0] {
        DATA_CONTINUOUS, DATA_BUFFERED, DATA_PACKET
    } rmc_data_mode_type;

    typedef enum logic [1:0] {
        MOD_RESET, MOD_OOK, MOD_FSK, MOD_DIRECT
    } rmc_mod_type;

    typedef enum logic [1:0] {
        SLICE_FIXED, SLICE_PEAK, SLICE_AVERAGE, SLICE_RESERVED
    } rmc_slicer_type;

endpackage

// ==== design/rmc_main_config.sv ====
// main configuration register bank with apb slave and decoded outputs
`timescale 1ns/1ns

// Overview of operation
// - mode bits 7-5 decode, standby at reset
// - band bits 4-2, sub-band bits 1-0
// - data mode continuous, buffered, else packet
// - modulation reset, ook, fsk, direct
// - ook slicer fixed, peak, average, reserved
// - if gain zero down to minus 13.5dB
// - deviation value d at index 2
// - bitrate coefficients c and d, d>=15
// - amp_ramp_time time from index 5 bits 7-6
// - low power lna bias on bit 5
// - bit 0 selects synthesizer counter set
// - two r,p,s counter sets with defaults
// - parameter groups placed at fixed addresses
// - vco trim bits 2-1, reset 11
module rmc_main_config
(
    // apb clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // decoded operating state
    output rmc_pkg::rmc_trx_mode_type  trx_mode,
    output logic      [2:0]  band_select,
    output logic      [1:0]  subband_select,
    output rmc_pkg::rmc_data_mode_type data_mode,
    output rmc_pkg::rmc_mod_type       modulation_select,
    output rmc_pkg::rmc_slicer_type    ook_slicer_type,
    output logic      [1:0]  if_gain_step,
    // modem coefficients
    output logic      [7:0]  fsk_deviation,
    output logic      [7:0]  bitrate_coeff_c,
    output logic      [7:0]  bitrate_coeff_d,
    output logic             bitrate_d_low,
    // transmitter and receiver trims
    output logic      [1:0]  amp_ramp_time,
    output logic             lna_low_power,
    output logic      [1:0]  vco_trim,
    output logic             counter_set_select,
    // active synthesizer counters
    output logic      [7:0]  ref_divider,
    output logic      [7:0]  p_count,
    output logic      [7:0]  s_count,
    // group strobes for the neighbouring parameter banks
    output logic      [5:0]  group_hit
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] regs_reg [rmc_pkg::NUM_MAIN_REGS]; // main bank bytes

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // true when idx lies in [lo, hi]
    function automatic logic in_range(input logic [4:0] idx,
                                      input logic [4:0] lo,
                                      input logic [4:0] hi);
        in_range = (idx >= lo) && (idx <= hi);
    endfunction

    wire logic [4:0] idx      = paddr[6:2];           // word index
    wire logic       aligned  = (paddr[1:0] == 2'h0)
                                && (paddr[31:7] == 25'h0);
    wire logic       main_hit = aligned
        && in_range(idx, rmc_pkg::IDX_MODE_BAND, rmc_pkg::IDX_MAIN_LAST);
    wire logic       access   = psel && penable;       // access phase
    wire logic       wr_hit   = access && pwrite && main_hit && pstrb[0];

    // group map of the wider register space
    assign group_hit[0] = aligned && in_range(idx, rmc_pkg::IDX_IRQ_FIRST,
                                              rmc_pkg::IDX_IRQ_LAST);
    assign group_hit[1] = aligned && in_range(idx, rmc_pkg::IDX_RX_FIRST,
                                              rmc_pkg::IDX_RX_LAST);
    assign group_hit[2] = aligned && in_range(idx, rmc_pkg::IDX_SYNC_FIRST,
                                              rmc_pkg::IDX_SYNC_LAST);
    assign group_hit[3] = aligned && (idx == rmc_pkg::IDX_TX_GROUP);
    assign group_hit[4] = aligned && (idx == rmc_pkg::IDX_OSC_GROUP);
    assign group_hit[5] = aligned && in_range(idx, rmc_pkg::IDX_PKT_FIRST,
                                              rmc_pkg::IDX_PKT_LAST);

    // zero-wait slave; unmapped or misaligned access answers an error
    assign pready  = 1'b1;
    assign pslverr = access && !main_hit;

    // ------------------------------------------------------------------
    // reset values per index
    // ------------------------------------------------------------------
    function automatic logic [7:0] reset_value(input int i);
        unique case (i)
            0:  reset_value = rmc_pkg::RST_MODE_BAND;
            1:  reset_value = rmc_pkg::RST_DATA_MOD;
            2:  reset_value = rmc_pkg::RST_FSK_DEV;
            3:  reset_value = rmc_pkg::RST_BR_C;
            4:  reset_value = rmc_pkg::RST_BR_D;
            5:  reset_value = rmc_pkg::RST_AMP_RAMP_TIME;
            6:  reset_value = rmc_pkg::RST_REF_DIV_A;
            7:  reset_value = rmc_pkg::RST_P_CNT_A;
            8:  reset_value = rmc_pkg::RST_S_CNT_A;
            9:  reset_value = rmc_pkg::RST_REF_DIV_B;
            10: reset_value = rmc_pkg::RST_P_CNT_B;
            default: reset_value = rmc_pkg::RST_S_CNT_B;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // register write, one byte per word, taken at the access edge
    // ------------------------------------------------------------------
    for (genvar g = 0; g < rmc_pkg::NUM_MAIN_REGS; g++)
    begin : g_reg
        localparam logic [7:0] MASK =
            (g == 5) ? rmc_pkg::MASK_AMP_RAMP_TIME : 8'hff;
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                regs_reg[g] <= reset_value(g);
            else if (wr_hit && (idx == 5'(g)))
                regs_reg[g] <= pwdata[7:0] & MASK;
        end
    end

    // ------------------------------------------------------------------
    // read data, registered from the bank at setup
    // ------------------------------------------------------------------
    wire logic [7:0] rd_byte = main_hit ? regs_reg[idx[3:0]] : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable && !pwrite)
            prdata <= {24'h0, rd_byte};
    end

    // ------------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------------
    wire logic [7:0] r0 = regs_reg[rmc_pkg::IDX_MODE_BAND[3:0]];
    wire logic [7:0] r1 = regs_reg[rmc_pkg::IDX_DATA_MOD[3:0]];
    wire logic [7:0] r5 = regs_reg[rmc_pkg::IDX_AMP_RAMP_TIME[3:0]];
    wire logic [2:0] mode_code = r0[rmc_pkg::POS_MODE +: 3];
    wire logic [1:0] dm_code   = r1[rmc_pkg::POS_DATAMODE +: 2];

    // transceiver mode; codes above transmit are undefined
    always_comb
    begin
        unique case (mode_code)
            3'h0:    trx_mode = rmc_pkg::TRX_SLEEP;
            3'h1:    trx_mode = rmc_pkg::TRX_STANDBY;
            3'h2:    trx_mode = rmc_pkg::TRX_SYNTH_ONLY;
            3'h3:    trx_mode = rmc_pkg::TRX_RECEIVE;
            3'h4:    trx_mode = rmc_pkg::TRX_TRANSMIT;
            default: trx_mode = rmc_pkg::TRX_UNDEFINED;
        endcase
    end

    // upper bit set means packet, lower bit ignored
    assign data_mode = dm_code[1] ? rmc_pkg::DATA_PACKET
                     : (dm_code[0] ? rmc_pkg::DATA_BUFFERED
                                   : rmc_pkg::DATA_CONTINUOUS);

    assign band_select    = r0[rmc_pkg::POS_BAND +: 3];
    assign subband_select = r0[rmc_pkg::POS_SUBBAND +: 2];
    assign modulation_select =
        rmc_pkg::rmc_mod_type'(r1[rmc_pkg::POS_MODSEL +: 2]);
    assign ook_slicer_type =
        rmc_pkg::rmc_slicer_type'(r1[rmc_pkg::POS_SLICER +: 2]);
    assign if_gain_step   = r1[rmc_pkg::POS_IFGAIN +: 2];

    // ------------------------------------------------------------------
    // coefficients and trims
    // ------------------------------------------------------------------
    assign fsk_deviation   = regs_reg[rmc_pkg::IDX_FSK_DEV[3:0]];
    assign bitrate_coeff_c = regs_reg[rmc_pkg::IDX_BR_C[3:0]];
    assign bitrate_coeff_d = regs_reg[rmc_pkg::IDX_BR_D[3:0]];
    // flags a d below the usable floor of 15
    assign bitrate_d_low   = bitrate_coeff_d < 8'h0f;

    assign amp_ramp_time      = r5[rmc_pkg::POS_RAMP +: 2];
    assign lna_low_power      = r5[rmc_pkg::POS_LOWPWR];
    assign vco_trim           = r5[rmc_pkg::POS_TRIM +: 2];
    assign counter_set_select = r5[rmc_pkg::POS_SETSEL];

    // active counter set follows the select bit
    assign ref_divider = counter_set_select
        ? regs_reg[rmc_pkg::IDX_REF_DIV_B[3:0]]
        : regs_reg[rmc_pkg::IDX_REF_DIV_A[3:0]];
    assign p_count = counter_set_select
        ? regs_reg[rmc_pkg::IDX_P_CNT_B[3:0]]
        : regs_reg[rmc_pkg::IDX_P_CNT_A[3:0]];
    assign s_count = counter_set_select
        ? regs_reg[rmc_pkg::IDX_S_CNT_B[3:0]]
        : regs_reg[rmc_pkg::IDX_S_CNT_A[3:0]];

endmodule // rmc_main_config

// ==== bench/rmc_main_config_monitor.sv ====
// checker of decoded outputs and bus refusals for the main config bank
`timescale 1ns/1ns
module rmc_mon
(
    // clock and reset
    input wire logic                       pclk,
    input wire logic                       presetn,
    // apb side
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [31:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [3:0]                 pstrb,
    input wire logic                       pslverr,
    // decoded outputs
    input wire rmc_pkg::rmc_trx_mode_type  trx_mode,
    input wire logic [2:0]                 band_select,
    input wire logic [1:0]                 subband_select,
    input wire rmc_pkg::rmc_data_mode_type data_mode,
    input wire logic [7:0]                 fsk_deviation,
    input wire logic [7:0]                 bitrate_coeff_d,
    input wire logic                       bitrate_d_low,
    input wire logic                       lna_low_power,
    input wire logic                       counter_set_select,
    input wire logic [5:0]                 group_hit
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // an accepted write to one byte address
    sequence wr_at(logic [31:0] a);
        psel && penable && pwrite && pstrb[0] && paddr == a;
    endsequence
    a_mode_transmit: assert property (
        wr_at(32'h0) ##0 (pwdata[7:5] == 3'b100)
        |=> trx_mode == rmc_pkg::TRX_TRANSMIT) else $error("mode not tx");
    a_band_follow: assert property (wr_at(32'h0) |=>
        band_select == $past(pwdata[4:2])
        && subband_select == $past(pwdata[1:0])) else $error("band wrong");
    a_packet_mode: assert property (wr_at(32'h4) ##0 pwdata[7] |=>
        data_mode == rmc_pkg::DATA_PACKET) else $error("not packet");
    a_dev_follow: assert property (wr_at(32'h8) |=>
        fsk_deviation == $past(pwdata[7:0])) else $error("dev wrong");
    a_d_low_flag: assert property (
        bitrate_d_low == (bitrate_coeff_d < 8'h0f)) else $error("d flag");
    a_lna_set: assert property (wr_at(32'h14) |=>
        lna_low_power == $past(pwdata[5])
        && counter_set_select == $past(pwdata[0])) else $error("idx5");
    a_irq_refused: assert property (psel && penable && paddr == 32'h30
        |-> pslverr && group_hit == 6'h01) else $error("irq group");
    a_main_taken: assert property (
        psel && penable && paddr == 32'h2c |-> !pslverr) else $error("idx11");
endmodule // rmc_mon

bind rmc_main_config rmc_mon u_mon (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .trx_mode, .band_select,
    .subband_select, .data_mode, .fsk_deviation, .bitrate_coeff_d,
    .bitrate_d_low, .lna_low_power, .counter_set_select, .group_hit);

// ==== bench/tb_rmc_main_config.sv ====
// self-checking bench for the main config register bank
`timescale 1ns/1ns
module tb_rmc_main_config;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = '0, pwdata = '0, rd, prdata;
    logic [3:0]  pstrb = 4'hf;
    logic        er, pready, pslverr, bitrate_d_low, lna_low_power;
    logic        counter_set_select;
    logic [5:0]  gh, group_hit;
    logic [2:0]  band_select;
    logic [1:0]  subband_select, if_gain_step, amp_ramp_time, vco_trim;
    logic [7:0]  fsk_deviation, bitrate_coeff_c, bitrate_coeff_d;
    logic [7:0]  ref_divider, p_count, s_count;
    rmc_pkg::rmc_trx_mode_type  trx_mode;
    rmc_pkg::rmc_data_mode_type data_mode;
    rmc_pkg::rmc_mod_type       modulation_select;
    rmc_pkg::rmc_slicer_type    ook_slicer_type;
    int fails = 0, cmp_count = 0, cyc = 0;
    // reset values, written values and unmapped group addresses
    localparam logic [7:0] RV [12] = '{8'h30, 8'h24, 8'h03, 8'h07, 8'h0f,
        8'hc6, 8'h6b, 8'h2a, 8'h1e, 8'h77, 8'h2f, 8'h19};
    localparam logic [7:0] WV [12] = '{8'h94, 8'h5a, 8'hff, 8'h00, 8'hff,
        8'h3f, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    localparam logic [31:0] GA [6] = '{32'h30, 32'h40, 32'h58, 32'h68,
        32'h6c, 32'h70};

    rmc_main_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .trx_mode, .band_select,
        .subband_select, .data_mode, .modulation_select, .ook_slicer_type,
        .if_gain_step, .fsk_deviation, .bitrate_coeff_c, .bitrate_coeff_d,
        .bitrate_d_low, .amp_ramp_time, .lna_low_power, .vco_trim,
        .counter_set_select, .ref_divider, .p_count, .s_count, .group_hit);

    // clock and hang limit
    always #20 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            fails++;
            wrap_up();
        end
    end

    // compare one value and count it
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; prdata, pslverr and group_hit are sampled at the access edge, other outputs on the next falling edge
    task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        gh = group_hit;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    // verdict and end of run
    task automatic wrap_up();
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk("mode at reset", 32'(trx_mode), 32'h1);
        chk("trim at reset", 32'(vco_trim), 32'h3);
        for (int i = 0; i < 12; i++)
        begin
            xfer(0, 32'(4 * i), 0);
            chk("reset value", rd, {24'h0, RV[i]});
        end
        for (int i = 0; i < 12; i++)
            xfer(1, 32'(4 * i), {24'hffffff, WV[i]});
        for (int i = 0; i < 12; i++)
        begin
            xfer(0, 32'(4 * i), 0);
            chk("readback", rd, {24'h0, WV[i] & (i == 5 ? 8'he7 : 8'hff)});
        end
        chk("deviation", 32'(fsk_deviation), 32'hff);
        chk("set b ref", 32'(ref_divider), 32'h44);
        chk("coeff c", 32'(bitrate_coeff_c), 32'h00);
        chk("set b s", 32'(s_count), 32'h66);
        for (int m = 0; m < 5; m++)
        begin
            xfer(1, 0, {24'h0, m[2:0], 5'b10010});
            chk("mode", 32'(trx_mode), 32'(m));
            chk("band", {band_select, subband_select}, 32'h12);
        end
        for (int k = 0; k < 4; k++)
        begin
            xfer(1, 32'h4, {24'h0, {4{k[1:0]}}});
            chk("data mode", 32'(data_mode), k[1] ? 32'h2 : 32'(k));
            chk("modulation", 32'(modulation_select), 32'(k));
            chk("slicer", 32'(ook_slicer_type), 32'(k));
            chk("if gain", 32'(if_gain_step), 32'(k));
            xfer(1, 32'h14, {24'h0, k[1:0], k[0], 2'b00, k[1:0], k[0]});
            chk("ramp", 32'(amp_ramp_time), 32'(k));
            chk("lna", 32'(lna_low_power), 32'(k[0]));
            chk("trim", 32'(vco_trim), 32'(k));
            chk("p count", 32'(p_count), k[0] ? 32'h55 : 32'h22);
        end
        xfer(1, 32'h10, 32'h0e);
        chk("d low", 32'(bitrate_d_low), 32'h1);
        xfer(1, 32'h10, 32'h0f);
        chk("d ok", 32'(bitrate_d_low), 32'h0);
        for (int j = 0; j < 6; j++)
        begin
            xfer(0, GA[j], 0);
            chk("group err", 32'(er), 32'h1);
            chk("group data", rd, 32'h0);
            chk("group hit", 32'(gh), 32'(1 << j));
        end
        xfer(1, 32'h9, 32'h5a);
        chk("unaligned err", 32'(er), 32'h1);
        chk("no write", 32'(fsk_deviation), 32'hff);
        // byte lane 0 disabled: the write must be ignored
        pstrb <= 4'he;
        xfer(1, 32'h8, 32'h12);
        chk("strobe off", 32'(fsk_deviation), 32'hff);
        pstrb <= 4'hf;
        // second reset in mid-run restores the defaults
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("dev after reset", 32'(fsk_deviation), 32'h03);
        chk("mode after reset", 32'(trx_mode), 32'h1);
        xfer(0, 32'h4, 0);
        chk("idx1 after reset", rd, 32'h24);
        wrap_up();
    end
endmodule // tb_rmc_main_config
